// >>> verilog/mbx_pkg.sv
// Package: register map, field layout, codes and reset values of the mailbox block
package mbx_pkg;

  // ******************************
  // Register map (byte addresses)
  // ******************************
  localparam logic [11:0] CONFIG_OFF = 12'h000;  // Module configuration
  localparam logic [11:0] TIMER_OFF = 12'h008;   // Free running timer, read only
  localparam logic [11:0] ENABLES_OFF = 12'h028; // Buffer interrupt enables, low 32
  localparam logic [11:0] FLAGS_OFF = 12'h030;   // Buffer flags, low 32, write one to clear
  localparam logic [11:0] MB_BASE = 12'h400;     // Message buffers, 16 bytes each
  localparam logic [11:0] MASK_BASE = 12'h800;   // Acceptance masks, one word each

  // ******************************
  // Configuration word fields
  // ******************************
  localparam int FREEZE_POS = 0;      // Freeze mode
  localparam int QUEUE_EN_POS = 1;    // Receive queue enable
  localparam int ABORT_EN_POS = 2;    // Abort enable
  localparam int BACKCOMPAT_POS = 3;  // Backwards compatibility
  localparam int LOCAL_FIELD_A_EN_POS = 4;     // Local priority enable
  localparam logic [4:0] CONFIG_RESET = 5'h01; // Out of reset in freeze

  // ******************************
  // Message buffer words and fields
  // ******************************
  localparam logic [1:0] WORD_CS = 2'h0;  // Control and status word
  localparam logic [1:0] WORD_ID = 2'h1;  // Identifier word
  localparam int CODE_LSB = 24;           // Code field [27:24]
  localparam int LEN_LSB = 16;            // Length field [19:16]
  localparam int LOCAL_FIELD_A_LSB = 29;           // Local priority [31:29] of id word

  // ******************************
  // Buffer codes
  // ******************************
  localparam logic [3:0] CODE_RX_INACTIVE = 4'h0;
  localparam logic [3:0] CODE_RX_FULL = 4'h2;
  localparam logic [3:0] CODE_TX_INACTIVE = 4'h8;
  localparam logic [3:0] CODE_TX_ABORT = 4'h9;

  // ******************************
  // Receive queue layout
  // ******************************
  localparam int QUEUE_REGION = 8;              // Buffers lent to the queue
  localparam logic [2:0] QUEUE_WARN_FILL = 3'h5; // Almost full level
  localparam logic [2:0] QUEUE_DEPTH = 3'h6;    // Entries in the queue
  localparam int OVERFLOW_BIT = 7;
  localparam int WARN_BIT = 6;
  localparam int AVAIL_BIT = 5;

endpackage

// >>> verilog/mbx_flags_masks.sv
// Mailbox flags, acceptance masks, activity, matching and transmit arbitration
// ******************************
// How it works
// - Successful transfer sets flag; enabled flag interrupts
// - Flag clears only on written one
// - Queue mode repurposes low eight flag bits
// - Queue mode: bit 7 means overflow
// - Queue mode: bit 6 means five-of-six full
// - Queue mode: bit 5 means frame waiting
// - Masks map to buffers or filter entries
// - Masks accessible only in freeze mode
// - Mask access errors without backcompat bit
// - Mask one compares bit, zero ignores
// - Many buffers; first eight form queue filters
// - Queue and mailbox accept concurrently, masked match
// - Codes 0000, 1000, 1001 are inactive
// - Control word write excludes buffer this run; here only a buffer whose code was active before the write
// - Priority field prefixes identifier for arbitration
// - Code 1000 deactivates; may still send silently; here a late send still stamps, retires and flags it
// - Sent buffer gets timestamp, code, flag
// - Abort mode blocks writes while flag set
// - Lowest priority, then id, then index wins
// ******************************
module mbx_flags_masks
  import mbx_pkg::*;
#(
  parameter int NUM_BUF = 32,  // Buffers handled here
  parameter int NUM_MASK = 64, // Mask words kept
  parameter int TS_W = 16      // Timestamp width
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic run_start,
  input wire logic [31:0] rx_id,
  input wire logic rx_done,
  input wire logic [4:0] rx_done_idx,
  input wire logic tx_done,
  input wire logic [4:0] tx_done_idx,
  input wire logic queue_overflow,
  input wire logic [2:0] queue_fill,
  output logic [NUM_BUF-1:0] mb_active,
  output logic rx_match_valid,
  output logic [4:0] rx_match_idx,
  output logic queue_hit_valid,
  output logic [2:0] queue_hit_idx,
  output logic tx_win_valid,
  output logic [4:0] tx_win_idx,
  output logic irq
);

  // ******************************
  // Helper functions
  // ******************************

  // Code is one that keeps the buffer out of all runs
  function automatic logic code_idle(input logic [3:0] code);
    code_idle = (code == CODE_RX_INACTIVE) || (code == CODE_TX_INACTIVE)
                || (code == CODE_TX_ABORT);
  endfunction

  // Codes with the top bit set are transmit buffers
  function automatic logic code_tx(input logic [3:0] code);
    code_tx = code[3];
  endfunction

  // Masked compare: mask one checks the bit, zero ignores it
  function automatic logic id_hit(input logic [31:0] a, input logic [31:0] b,
                                  input logic [31:0] m);
    id_hit = ((a ^ b) & m) == 32'h0000_0000;
  endfunction

  // ******************************
  // State
  // ******************************
  logic [4:0] config_q;                 // Configuration bits
  logic [31:0] enables_q;               // Interrupt enables
  logic [31:0] flags_q;                 // Sticky buffer flags
  logic [TS_W-1:0] timer_q;             // Free running timer
  logic [3:0] code_q [NUM_BUF];         // Buffer codes
  logic [3:0] len_q [NUM_BUF];          // Buffer lengths
  logic [TS_W-1:0] stamp_q [NUM_BUF];   // Buffer timestamps
  logic [31:0] id_q [NUM_BUF];          // Identifier words
  logic [NUM_BUF-1:0] excl_q;           // Excluded from current run
  logic [31:0] mask_mem [NUM_MASK];     // Acceptance masks, no reset
  logic [2:0] fill_q;                   // Previous queue fill
  logic [31:0] rdata_q;                 // Read data captured at setup
  logic err_q;                          // Error captured at setup

  // Configuration views
  wire logic freeze = config_q[FREEZE_POS]; // Masks open to software
  wire logic queue_en = config_q[QUEUE_EN_POS]; // Low eight buffers lent to queue
  wire logic abort_en = config_q[ABORT_EN_POS]; // Sent buffers lock until flag clear
  wire logic backcompat = config_q[BACKCOMPAT_POS]; // Masks reachable at all
  wire logic local_field_a_en = config_q[LOCAL_FIELD_A_EN_POS]; // Priority prefix in arbitration

  // ******************************
  // Address decode
  // ******************************
  wire logic setup = psel && !penable; // First cycle of a transfer
  wire logic access = psel && penable; // Answered at once
  wire logic in_mb = (paddr >= MB_BASE) && (paddr < MB_BASE + 12'(NUM_BUF * 16))
                     && (paddr[3:2] <= WORD_ID);
  wire logic in_mask = (paddr >= MASK_BASE) && (paddr < MASK_BASE + 12'(NUM_MASK * 4));
  wire logic [4:0] mb_idx = paddr[8:4]; // Buffer number
  wire logic [1:0] mb_word = paddr[3:2]; // Word within the buffer
  wire logic [5:0] mask_idx = paddr[7:2]; // Mask number
  wire logic mapped = in_mb || in_mask || paddr == CONFIG_OFF || paddr == TIMER_OFF
                      || paddr == ENABLES_OFF || paddr == FLAGS_OFF;

  // Writes are taken in the access phase; no wait states
  wire logic wr = access && pwrite;
  wire logic mask_err = in_mask && !backcompat;
  // Finished transmit buffer stays locked until its flag is cleared
  wire logic mb_blocked = abort_en && code_tx(code_q[mb_idx]) && flags_q[mb_idx];

  // ******************************
  // APB answer
  // ******************************

  // Read data and error are flopped at setup, shown in access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end
    else if (setup)
    begin
      err_q <= !mapped || mask_err;
      rdata_q <= 32'h0000_0000;
      if (in_mask)
      begin
        // Outside freeze masks read as zero
        if (freeze && backcompat)
          rdata_q <= mask_mem[mask_idx];
      end
      else if (in_mb)
      begin
        if (mb_word == WORD_CS)
          rdata_q <= {4'h0, code_q[mb_idx], 4'h0, len_q[mb_idx], 16'(stamp_q[mb_idx])};
        else
          rdata_q <= id_q[mb_idx];
      end
      else if (paddr == CONFIG_OFF)
        rdata_q <= {27'h000_0000, config_q};
      else if (paddr == TIMER_OFF)
        rdata_q <= 32'(timer_q);
      else if (paddr == ENABLES_OFF)
        rdata_q <= enables_q;
      else if (paddr == FLAGS_OFF)
        rdata_q <= flags_q;
    end
  end

  assign prdata = rdata_q;
  assign pready = access;
  assign pslverr = access && err_q;

  // ******************************
  // Configuration and enables
  // ******************************

  // Plain read/write control words
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      config_q <= CONFIG_RESET;
      enables_q <= 32'h0000_0000;
    end
    else if (wr)
    begin
      if (paddr == CONFIG_OFF)
        config_q <= pwdata[4:0];
      if (paddr == ENABLES_OFF)
        enables_q <= pwdata;
    end
  end

  // Free running timer, source of timestamps
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_q <= '0;
    else
      timer_q <= timer_q + 1'b1;
  end

  // ******************************
  // Acceptance masks
  // ******************************

  // Memory-like storage: no reset, software must load before use
  always_ff @(posedge pclk)
  begin
    // Writes outside freeze or without backcompat are dropped
    if (wr && in_mask && freeze && backcompat)
      mask_mem[mask_idx] <= pwdata;
  end

  // ******************************
  // Flags
  // ******************************
  logic [31:0] flag_set;

  // Warning fires when fill first reaches five of six
  wire logic warn_rise = (fill_q < QUEUE_WARN_FILL) && (queue_fill >= QUEUE_WARN_FILL);

  // Gather set events; queue mode takes over the low eight bits
  always_comb
  begin
    flag_set = 32'h0000_0000;
    if (rx_done && !(queue_en && rx_done_idx < 5'(QUEUE_REGION)))
      flag_set[rx_done_idx] = 1'b1;
    if (tx_done && !(queue_en && tx_done_idx < 5'(QUEUE_REGION)))
      flag_set[tx_done_idx] = 1'b1;
    if (queue_en)
    begin
      flag_set[OVERFLOW_BIT] = queue_overflow;
      flag_set[WARN_BIT] = warn_rise;
      flag_set[AVAIL_BIT] = queue_fill != 3'h0;
    end
  end

  // Write one clears, write zero keeps
  wire logic [31:0] flag_clr = (wr && paddr == FLAGS_OFF) ? pwdata : 32'h0000_0000;

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_q <= 32'h0000_0000;
      fill_q <= 3'h0;
    end
    else
    begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
      fill_q <= queue_fill;
    end
  end

  // Live interrupt: enable changes act at once
  assign irq = |(flags_q & enables_q);

  // ******************************
  // Message buffer words
  // ******************************
  wire logic cs_wr = wr && in_mb && mb_word == WORD_CS && !mb_blocked; // Landed word 0 write

  // Engine updates win over a CPU write to the same buffer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_BUF; i++)
      begin
        code_q[i] <= CODE_RX_INACTIVE;
        len_q[i] <= 4'h0;
        stamp_q[i] <= '0;
        id_q[i] <= 32'h0000_0000;
      end
    end
    else
    begin
      // CPU access, blocked on a locked transmit buffer
      if (wr && in_mb && !mb_blocked)
      begin
        if (mb_word == WORD_CS)
        begin
          // Writing 1000 or 1001 retires the buffer at once
          code_q[mb_idx] <= pwdata[CODE_LSB +: 4];
          len_q[mb_idx] <= pwdata[LEN_LSB +: 4];
        end
        else
          id_q[mb_idx] <= pwdata;
      end
      // Move-in: store id, stamp and mark full
      if (rx_done)
      begin
        id_q[rx_done_idx] <= rx_id;
        stamp_q[rx_done_idx] <= timer_q;
        code_q[rx_done_idx] <= CODE_RX_FULL;
      end
      // Sent: stamp and retire, even if software deactivated it
      if (tx_done)
      begin
        stamp_q[tx_done_idx] <= timer_q;
        code_q[tx_done_idx] <= CODE_TX_INACTIVE;
      end
    end
  end

  // Exclusion from the run in progress; a write in the start cycle still counts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      excl_q <= '0;
    else
    begin
      for (int i = 0; i < NUM_BUF; i++)
      begin
        if (cs_wr && mb_idx == 5'(i) && !code_idle(code_q[i]))
          excl_q[i] <= 1'b1;
        else if (run_start)
          excl_q[i] <= 1'b0;
      end
    end
  end

  // ******************************
  // Activity
  // ******************************
  genvar g;
  generate
    for (g = 0; g < NUM_BUF; g++)
    begin : gen_active
      // Queue region buffers are not mailboxes while the queue runs
      assign mb_active[g] = !code_idle(code_q[g]) && !excl_q[g]
                            && !(queue_en && g < QUEUE_REGION);
    end
  endgenerate

  // ******************************
  // Receive matching
  // ******************************

  // Mailbox match: same-index mask, lowest buffer wins
  always_comb
  begin
    rx_match_valid = 1'b0;
    rx_match_idx = 5'h00;
    for (int i = NUM_BUF - 1; i >= 0; i--)
    begin
      if (mb_active[i] && !code_tx(code_q[i]) && id_hit(id_q[i], rx_id, mask_mem[i]))
      begin
        rx_match_valid = 1'b1;
        rx_match_idx = 5'(i);
      end
    end
  end

  // Queue filters run beside the mailboxes; masks 0..7 serve them
  always_comb
  begin
    queue_hit_valid = 1'b0;
    queue_hit_idx = 3'h0;
    for (int i = QUEUE_REGION - 1; i >= 0; i--)
    begin
      if (queue_en && queue_fill < QUEUE_DEPTH && id_hit(id_q[i], rx_id, mask_mem[i]))
      begin
        queue_hit_valid = 1'b1;
        queue_hit_idx = 3'(i);
      end
    end
  end

  // ******************************
  // Transmit arbitration
  // ******************************
  logic [31:0] best_key;
  logic [31:0] key;

  // Lowest key wins; strict compare keeps the lowest index on ties
  always_comb
  begin
    tx_win_valid = 1'b0;
    tx_win_idx = 5'h00;
    best_key = 32'hFFFF_FFFF;
    key = 32'h0000_0000;
    for (int i = 0; i < NUM_BUF; i++)
    begin
      // Priority field is prefixed only for arbitration, never sent
      key = local_field_a_en ? id_q[i] : {3'h0, id_q[i][LOCAL_FIELD_A_LSB-1:0]};
      if (mb_active[i] && code_tx(code_q[i]) && (!tx_win_valid || key < best_key))
      begin
        tx_win_valid = 1'b1;
        tx_win_idx = 5'(i);
        best_key = key;
      end
    end
  end

endmodule

// >>> testbench/mbx_flags_masks_checker.sv
// Checker of the mailbox block's port behaviour
module mbx_flags_masks_checker
  import mbx_pkg::*;
#(
  parameter int NUM_BUF = 32
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic tx_done,
  input wire logic [4:0] tx_done_idx,
  input wire logic [2:0] queue_fill,
  input wire logic [NUM_BUF-1:0] mb_active,
  input wire logic rx_match_valid,
  input wire logic [4:0] rx_match_idx,
  input wire logic queue_hit_valid,
  input wire logic tx_win_valid,
  input wire logic [4:0] tx_win_idx,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Register shadows
  // ****
  logic [4:0] cfg_q; // Configuration as last written
  logic [31:0] en_q; // Enables as last written
  wire logic acc = psel && penable;
  wire logic wr_acc = acc && pwrite;
  wire logic cs_wr = wr_acc && paddr[11:9] == 3'b010 && paddr[3:0] == 4'h0;
  wire logic mask_acc = acc && paddr[11:8] == 4'h8;
  wire logic [3:0] code = pwdata[27:24];
  wire logic idle = code == CODE_RX_INACTIVE || code == CODE_TX_INACTIVE || code == CODE_TX_ABORT;

  // Writes land in the access cycle, so shadows follow the same edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q <= CONFIG_RESET;
      en_q <= 32'h0000_0000;
    end
    else if (wr_acc)
    begin
      if (paddr == CONFIG_OFF)
        cfg_q <= pwdata[4:0];
      if (paddr == ENABLES_OFF)
        en_q <= pwdata;
    end
  end

  // ****
  // Properties
  // ****
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  idle_code_a: assert property (
    cs_wr && idle |=> !mb_active[$past(paddr[8:4])])
    else $error("idle code left buffer active");
  run_exclude_a: assert property (
    cs_wr && !idle && mb_active[paddr[8:4]] |=> !mb_active[$past(paddr[8:4])])
    else $error("written buffer kept in run");
  queue_room_a: assert property (
    queue_hit_valid |-> cfg_q[QUEUE_EN_POS] && queue_fill < QUEUE_DEPTH)
    else $error("queue hit without room");
  winner_active_a: assert property (
    tx_win_valid |-> mb_active[tx_win_idx])
    else $error("inactive arbitration winner");
  match_region_a: assert property (
    rx_match_valid |-> mb_active[rx_match_idx] && !(cfg_q[QUEUE_EN_POS] && rx_match_idx < 5'd8))
    else $error("bad mailbox match");
  mask_error_a: assert property (
    mask_acc && !cfg_q[BACKCOMPAT_POS] |-> pslverr)
    else $error("mask access without error");
  mask_hidden_a: assert property (
    mask_acc && !pwrite && cfg_q[BACKCOMPAT_POS] && !cfg_q[FREEZE_POS]
      |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("mask visible outside freeze");
  irq_masked_a: assert property (
    wr_acc && paddr == ENABLES_OFF && pwdata == 32'h0000_0000 |=> !irq)
    else $error("irq with all enables off");
  send_irq_a: assert property (
    tx_done && en_q[tx_done_idx] && !(cfg_q[QUEUE_EN_POS] && tx_done_idx < 5'd8) |=> irq)
    else $error("no irq after enabled send");
endmodule

// >>> testbench/can_far_node.sv
// Far-side model: frame events of other bus nodes as seen by the mailbox
module can_far_node
  import mbx_pkg::*;
(
  input wire logic pclk,
  output logic run_start,
  output logic [31:0] rx_id,
  output logic rx_done,
  output logic [4:0] rx_done_idx,
  output logic tx_done,
  output logic [4:0] tx_done_idx,
  output logic queue_overflow,
  output logic [2:0] queue_fill
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet bus at time zero
  initial
  begin
    run_start = 1'b0;
    rx_id = 32'h0000_0000;
    rx_done = 1'b0;
    rx_done_idx = 5'h00;
    tx_done = 1'b0;
    tx_done_idx = 5'h00;
    queue_overflow = 1'b0;
    queue_fill = 3'h0;
  end

  // One event after dly idle cycles; index inverts afterwards, so stale use shows
  task automatic pulse(input int kind, input logic [4:0] idx, input int dly);
    repeat (dly) @(posedge pclk);
    @(posedge pclk);
    tx_done <= kind == 0;
    rx_done <= kind == 1;
    queue_overflow <= kind == 2;
    run_start <= kind == 3;
    tx_done_idx <= idx;
    rx_done_idx <= idx;
    @(posedge pclk);
    {tx_done, rx_done, queue_overflow, run_start} <= 4'h0;
    tx_done_idx <= ~idx;
    rx_done_idx <= ~idx;
  endtask

  // Identifier of the frame on the bus
  task automatic set_id(input logic [31:0] v);
    @(posedge pclk);
    rx_id <= v;
  endtask

  // Queue occupancy level
  task automatic set_fill(input logic [2:0] v);
    @(posedge pclk);
    queue_fill <= v;
  endtask
endmodule

// >>> testbench/mbx_flags_masks_tb_top.sv
// Testbench top: APB register tests of the mailbox block
module mbx_flags_masks_tb_top
  import mbx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, irq;
  logic run_start, rx_done, tx_done, queue_overflow, rx_match_valid, queue_hit_valid, tx_win_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, rx_id, mb_active;
  logic [4:0] rx_done_idx, tx_done_idx, rx_match_idx, tx_win_idx;
  logic [2:0] queue_fill, queue_hit_idx;
  int error_cnt = 0;
  int n_tests = 0;

  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  mbx_flags_masks u_mbx_flags_masks (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .run_start(run_start), .rx_id(rx_id),
    .rx_done(rx_done), .rx_done_idx(rx_done_idx), .tx_done(tx_done),
    .tx_done_idx(tx_done_idx), .queue_overflow(queue_overflow), .queue_fill(queue_fill),
    .mb_active(mb_active), .rx_match_valid(rx_match_valid), .rx_match_idx(rx_match_idx),
    .queue_hit_valid(queue_hit_valid), .queue_hit_idx(queue_hit_idx),
    .tx_win_valid(tx_win_valid), .tx_win_idx(tx_win_idx), .irq(irq));
  can_far_node u_can_far_node (.pclk(pclk), .run_start(run_start), .rx_id(rx_id),
    .rx_done(rx_done), .rx_done_idx(rx_done_idx), .tx_done(tx_done),
    .tx_done_idx(tx_done_idx), .queue_overflow(queue_overflow), .queue_fill(queue_fill));

  // Word addresses of buffers and masks
  function automatic logic [11:0] cs(input int i);
    return MB_BASE + 12'(i * 16);
  endfunction
  function automatic logic [11:0] mk(input int j);
    return MASK_BASE + 12'(j * 4);
  endfunction

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // APB transfer: request held until pready seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a stuck wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    chk({31'h0, rerr}, {31'h0, ee});
    if (!ee)
      chk(rdat, exp);
  endtask

  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog well beyond the expected run of a few hundred cycles
  initial
  begin
    #200_000;
    error_cnt++;
    complete_run;
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(CONFIG_OFF, 32'h0000_0001, 1'b0);
    rd(FLAGS_OFF, 32'h0000_0000, 1'b0);
    rd(12'h004, 32'h0000_0000, 1'b1);
    rd(mk(9), 32'h0000_0000, 1'b1);
    $display("test reset done");
    wr(CONFIG_OFF, 32'h0000_0009);
    for (int j = 0; j < 64; j++)
      wr(mk(j), 32'hFFFF_FFFF);
    wr(mk(9), 32'hFFFF_FFF0);
    rd(mk(9), 32'hFFFF_FFF0, 1'b0);
    wr(cs(9) + 12'h004, 32'h0000_0123);
    wr(cs(9), 32'h0400_0000);
    u_can_far_node.set_id(32'h0000_012A);
    @(negedge pclk);
    chk(32'({rx_match_valid, rx_match_idx}), 32'h0000_0029);
    u_can_far_node.set_id(32'h0000_0133);
    @(negedge pclk);
    chk(32'(rx_match_valid), 32'h0000_0000);
    u_can_far_node.pulse(1, 5'd9, 0);
    wr(CONFIG_OFF, 32'h0000_0008);
    rd(mk(9), 32'h0000_0000, 1'b0);
    wr(mk(9), 32'h0000_0000);
    $display("test masks done");
    wr(cs(10) + 12'h004, 32'h0000_0200);
    wr(cs(11) + 12'h004, 32'h0000_0100);
    wr(cs(10), 32'h0C00_0000);
    wr(cs(11), 32'h0C00_0000);
    @(negedge pclk);
    chk(32'({tx_win_valid, tx_win_idx}), 32'h0000_002B);
    wr(CONFIG_OFF, 32'h0000_0018);
    wr(cs(11) + 12'h004, 32'h2000_0100);
    @(negedge pclk);
    chk(32'({tx_win_valid, tx_win_idx}), 32'h0000_002A);
    wr(ENABLES_OFF, 32'h0000_0800);
    u_can_far_node.pulse(0, 5'd11, 3);
    @(negedge pclk);
    chk(32'(irq), 32'h0000_0001);
    apb(1'b0, cs(11), 32'h0000_0000);
    chk(32'(rdat[27:24]), 32'h0000_0008);
    wr(FLAGS_OFF, 32'h0000_0000);
    rd(FLAGS_OFF, 32'h0000_0A00, 1'b0);
    wr(FLAGS_OFF, 32'h0000_0800);
    rd(FLAGS_OFF, 32'h0000_0200, 1'b0);
    wr(ENABLES_OFF, 32'h0000_0200);
    @(negedge pclk);
    chk(32'(irq), 32'h0000_0001);
    wr(ENABLES_OFF, 32'h0000_0000);
    $display("test send done");
    for (int k = 0; k < 3; k++)
    begin
      wr(cs(10), {4'h0, (k == 0) ? 4'h0 : 4'(7 + k), 24'h0});
      @(negedge pclk);
      chk(32'(mb_active[10]), 32'h0000_0000);
      wr(cs(10), 32'h0C00_0000);
      // Writing the idle code excluded the buffer; a new run lifts that
      u_can_far_node.pulse(3, 5'd0, 0);
      @(negedge pclk);
      chk(32'(mb_active[10]), 32'h0000_0001);
    end
    wr(cs(10), 32'h0C00_0000);
    @(negedge pclk);
    chk(32'(mb_active[10]), 32'h0000_0000);
    u_can_far_node.pulse(3, 5'd0, 0);
    @(negedge pclk);
    chk(32'(mb_active[10]), 32'h0000_0001);
    wr(CONFIG_OFF, 32'h0000_001C);
    u_can_far_node.pulse(0, 5'd10, 0);
    wr(cs(10) + 12'h004, 32'h0000_0555);
    rd(cs(10) + 12'h004, 32'h0000_0200, 1'b0);
    wr(FLAGS_OFF, 32'h0000_0400);
    wr(cs(10) + 12'h004, 32'h0000_0555);
    rd(cs(10) + 12'h004, 32'h0000_0555, 1'b0);
    $display("test codes done");
    wr(CONFIG_OFF, 32'h0000_000B);
    wr(mk(0), 32'h0000_0000);
    wr(FLAGS_OFF, 32'hFFFF_FFFF);
    u_can_far_node.set_fill(3'd5);
    @(negedge pclk);
    chk(32'({queue_hit_valid, queue_hit_idx}), 32'h0000_0008);
    u_can_far_node.pulse(2, 5'd0, 0);
    u_can_far_node.pulse(1, 5'd2, 0);
    u_can_far_node.set_fill(3'd6);
    @(negedge pclk);
    chk(32'(queue_hit_valid), 32'h0000_0000);
    rd(FLAGS_OFF, 32'h0000_00E0, 1'b0);
    rd(mk(9), 32'hFFFF_FFF0, 1'b0);
    $display("test queue done");
    complete_run;
  end
endmodule

bind mbx_flags_masks mbx_flags_masks_checker #(.NUM_BUF(NUM_BUF)) u_mbx_flags_masks_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .tx_done(tx_done),
  .tx_done_idx(tx_done_idx), .queue_fill(queue_fill), .mb_active(mb_active),
  .rx_match_valid(rx_match_valid), .rx_match_idx(rx_match_idx),
  .queue_hit_valid(queue_hit_valid), .tx_win_valid(tx_win_valid),
  .tx_win_idx(tx_win_idx), .irq(irq));
